// File: src/cfe_pkg.sv
/*
  Constants for the condition flag evaluator: register offsets, field layouts,
  flag positions, condition codes, operation and flag-action encodings.
  Assumes a 32-bit data path and a byte-addressed APB register bus.
*/
// Operation
// - codes 0000,0001,0010,0100,1101 true when overflow,carry,zero,sign,saturated set
// - codes 1000,1001,1010,1100 true when overflow,carry,zero,sign are clear
// - 0011 true when carry or zero; 1011 true when both clear
// - code 0101 is always true whatever the flags hold
// - 0110 true when sign xor overflow; 1110 when that is zero
// - 0111 true when (sign xor overflow) or zero; 1111 when that is zero
// - saturation clamps above 7fffffff and below 80000000, else passes unchanged
// - each flag is kept, cleared, taken from result, or restored from saved copy
// - zero and sign extension widen an operand to the full 32-bit word
// - trap vector is a 5-bit field holding 00 to 1f
// - third register operand takes division remainder or product high word
// - bit operations use a 3-bit field picking one of eight byte bits
package cfe_pkg;
  localparam int CFE_DW = 32;
  localparam int CFE_AW = 8;
  localparam int CFE_NFLAGS = 5;
  localparam int CFE_COND_W = 4;
  localparam int CFE_TRAP_W = 5;
  localparam int CFE_EXT_W = 5;
  localparam int CFE_BYTE_W = 8;
  localparam int CFE_BITN_W = 3;

  // register byte offsets
  localparam logic [CFE_AW-1:0] CFE_ADDR_FLAGS = 8'h00;
  localparam logic [CFE_AW-1:0] CFE_ADDR_COND = 8'h04;
  localparam logic [CFE_AW-1:0] CFE_ADDR_FACT = 8'h08;
  localparam logic [CFE_AW-1:0] CFE_ADDR_SAVED = 8'h0c;
  localparam logic [CFE_AW-1:0] CFE_ADDR_OPA = 8'h10;
  localparam logic [CFE_AW-1:0] CFE_ADDR_OPB = 8'h14;
  localparam logic [CFE_AW-1:0] CFE_ADDR_CMD = 8'h18;
  localparam logic [CFE_AW-1:0] CFE_ADDR_RESULT = 8'h1c;
  localparam logic [CFE_AW-1:0] CFE_ADDR_THIRD = 8'h20;
  localparam logic [CFE_AW-1:0] CFE_ADDR_EXT = 8'h24;
  localparam logic [CFE_AW-1:0] CFE_ADDR_TRAP = 8'h28;
  localparam logic [CFE_AW-1:0] CFE_ADDR_BIT = 8'h2c;

  // flag positions
  localparam int CFE_F_CARRY = 0;
  localparam int CFE_F_OVERFLOW = 1;
  localparam int CFE_F_SIGN = 2;
  localparam int CFE_F_ZERO = 3;
  localparam int CFE_F_SATURATED = 4;

  // condition codes
  localparam logic [3:0] CFE_CC_OVERFLOW = 4'h0;
  localparam logic [3:0] CFE_CC_CARRY = 4'h1;
  localparam logic [3:0] CFE_CC_ZERO = 4'h2;
  localparam logic [3:0] CFE_CC_NOT_HIGHER = 4'h3;
  localparam logic [3:0] CFE_CC_NEGATIVE = 4'h4;
  localparam logic [3:0] CFE_CC_ALWAYS = 4'h5;
  localparam logic [3:0] CFE_CC_SIGNED_LESS = 4'h6;
  localparam logic [3:0] CFE_CC_SIGNED_LESS_EQ = 4'h7;
  localparam logic [3:0] CFE_CC_NO_OVERFLOW = 4'h8;
  localparam logic [3:0] CFE_CC_NO_CARRY = 4'h9;
  localparam logic [3:0] CFE_CC_NOT_ZERO = 4'ha;
  localparam logic [3:0] CFE_CC_HIGHER = 4'hb;
  localparam logic [3:0] CFE_CC_POSITIVE = 4'hc;
  localparam logic [3:0] CFE_CC_SATURATION = 4'hd;
  localparam logic [3:0] CFE_CC_SIGNED_GREATER_EQ = 4'he;
  localparam logic [3:0] CFE_CC_SIGNED_GREATER = 4'hf;
  localparam int CFE_CC_INV_BIT = 3;

  // saturation limits
  localparam logic [CFE_DW-1:0] CFE_SAT_MAX = 32'h7fffffff;
  localparam logic [CFE_DW-1:0] CFE_SAT_MIN = 32'h80000000;

  // command register fields and operations
  localparam int CFE_CMD_OP_LO = 0;
  localparam int CFE_CMD_OP_HI = 2;
  localparam int CFE_CMD_SAT_EN = 3;
  localparam logic [2:0] CFE_OP_ADD = 3'h0;
  localparam logic [2:0] CFE_OP_SUB = 3'h1;
  localparam logic [2:0] CFE_OP_MUL = 3'h2;
  localparam logic [2:0] CFE_OP_DIV = 3'h3;
  localparam logic [2:0] CFE_OP_SEXT = 3'h4;
  localparam logic [2:0] CFE_OP_ZEXT = 3'h5;
  localparam logic [2:0] CFE_OP_BITOP = 3'h6;

  // flag actions, two bits per flag in the action register
  localparam logic [1:0] CFE_FA_KEEP = 2'h0;
  localparam logic [1:0] CFE_FA_CLEAR = 2'h1;
  localparam logic [1:0] CFE_FA_RESULT = 2'h2;
  localparam logic [1:0] CFE_FA_RESTORE = 2'h3;

  // condition register and bit-operation register fields
  localparam int CFE_COND_MET_BIT = 8;
  localparam int CFE_BIT_NUM_LO = 8;
  localparam int CFE_BIT_OP_LO = 11;
  localparam int CFE_BIT_CTRL_W = 13;
  localparam logic [1:0] CFE_BOP_TEST = 2'h0;
  localparam logic [1:0] CFE_BOP_SET = 2'h1;
  localparam logic [1:0] CFE_BOP_CLEAR = 2'h2;
  localparam logic [1:0] CFE_BOP_INVERT = 2'h3;
endpackage

// File: src/cfe_cond_eval.sv
/*
  Combinational condition evaluator: a 4-bit condition code against the five
  status flags. Assumes flags and code are stable in the cycle they are read.
*/
`timescale 1ns/1ps
module cfe_cond_eval
  import cfe_pkg::*;
(
  // condition and flags
  input wire logic [CFE_COND_W-1:0] code_in,
  input wire logic [CFE_NFLAGS-1:0] flags_in,
  // verdict
  output logic met_out
);
  logic base;
  logic sxo;

  always_comb begin
    sxo = flags_in[CFE_F_SIGN] ^ flags_in[CFE_F_OVERFLOW];
    case (code_in[CFE_CC_INV_BIT-1:0])
      CFE_CC_OVERFLOW[2:0]: base = flags_in[CFE_F_OVERFLOW];
      CFE_CC_CARRY[2:0]: base = flags_in[CFE_F_CARRY];
      CFE_CC_ZERO[2:0]: base = flags_in[CFE_F_ZERO];
      CFE_CC_NOT_HIGHER[2:0]: base = flags_in[CFE_F_CARRY] | flags_in[CFE_F_ZERO];
      CFE_CC_NEGATIVE[2:0]: base = flags_in[CFE_F_SIGN];
      CFE_CC_SIGNED_LESS[2:0]: base = sxo;
      CFE_CC_SIGNED_LESS_EQ[2:0]: base = sxo | flags_in[CFE_F_ZERO];
      default: base = 1'b1;
    endcase
    if (code_in[CFE_CC_INV_BIT-1:0] == CFE_CC_ALWAYS[2:0]) begin
      // the pair 0101/1101 is no complement: always versus saturated
      met_out = code_in[CFE_CC_INV_BIT] ? flags_in[CFE_F_SATURATED] : 1'b1;
    end else begin
      met_out = base ^ code_in[CFE_CC_INV_BIT];
    end
  end
endmodule // cfe_cond_eval

// File: src/cfe_saturator.sv
/*
  Signed saturation of a result carried one bit wider than the word.
  Assumes the input is a true two's-complement sum with no lost bits.
*/
`timescale 1ns/1ps
module cfe_saturator
  import cfe_pkg::*;
#(
  parameter int DW = CFE_DW
) (
  // wide result
  input wire logic [DW:0] wide_in,
  // clamped word
  output logic [DW-1:0] word_out,
  output logic clamped_out
);
  always_comb begin
    clamped_out = wide_in[DW] ^ wide_in[DW-1];
    if (!clamped_out) begin
      word_out = wide_in[DW-1:0];
    end else if (wide_in[DW]) begin
      word_out = {1'b1, {(DW-1){1'b0}}};
    end else begin
      word_out = {1'b0, {(DW-1){1'b1}}};
    end
  end
endmodule // cfe_saturator

// File: src/cfe_condition_flag_evaluator.sv
/*
  Condition flag evaluator with flag-update actions, saturating arithmetic,
  operand extension, bit operations and third-operand capture, on an APB slave.
  Assumes a zero-wait APB master; the core reads flags, verdict and trap vector.
*/
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module cfe_condition_flag_evaluator
  import cfe_pkg::*;
#(
  parameter int DW = CFE_DW
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [CFE_AW-1:0] paddr_in,
  input wire logic [DW-1:0] pwdata_in,
  output logic [DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // core-facing state
  output logic [CFE_NFLAGS-1:0] flags_out,
  output logic cond_met_out,
  output logic [CFE_TRAP_W-1:0] trap_vector_out
);
  logic [CFE_NFLAGS-1:0] flags;
  logic [CFE_NFLAGS-1:0] saved_flags;
  logic [CFE_COND_W-1:0] cond_code;
  logic [2*CFE_NFLAGS-1:0] flag_act;
  logic [DW-1:0] opa;
  logic [DW-1:0] opb;
  logic [DW-1:0] result;
  logic [DW-1:0] third_register_operand;
  logic [CFE_EXT_W-1:0] ext_width;
  logic [CFE_TRAP_W-1:0] trap_vector;
  logic [CFE_BIT_CTRL_W-1:0] bit_ctrl;
  logic cond_met;
  logic [DW-1:0] rdata;

  logic [CFE_NFLAGS-1:0] next_flags;
  logic [CFE_NFLAGS-1:0] next_saved_flags;
  logic [CFE_COND_W-1:0] next_cond_code;
  logic [2*CFE_NFLAGS-1:0] next_flag_act;
  logic [DW-1:0] next_opa;
  logic [DW-1:0] next_opb;
  logic [DW-1:0] next_result;
  logic [DW-1:0] next_third_register_operand;
  logic [CFE_EXT_W-1:0] next_ext_width;
  logic [CFE_TRAP_W-1:0] next_trap_vector;
  logic [CFE_BIT_CTRL_W-1:0] next_bit_ctrl;
  logic next_cond_met;
  logic [DW-1:0] next_rdata;

  logic mapped;
  logic setup_rd;
  logic wr_acc;
  logic cmd_fire;
  logic [2:0] op;
  logic sat_en;
  logic cond_now;
  logic [DW:0] sum_wide;
  logic [DW:0] carry_sum;
  logic [DW-1:0] sat_word;
  logic sat_clamp;
  logic [2*DW-1:0] product;
  logic [DW-1:0] ext_mask;
  logic [CFE_BYTE_W-1:0] bit_byte;
  logic [CFE_BITN_W-1:0] bit_num;
  logic [1:0] bit_op;
  logic [CFE_BYTE_W-1:0] new_byte;
  logic [DW-1:0] op_res;
  logic [DW-1:0] op_third;
  logic [CFE_NFLAGS-1:0] res_flags;

  function automatic logic cfe_is_mapped(input logic [CFE_AW-1:0] a);
    case (a)
      CFE_ADDR_FLAGS, CFE_ADDR_COND, CFE_ADDR_FACT, CFE_ADDR_SAVED,
      CFE_ADDR_OPA, CFE_ADDR_OPB, CFE_ADDR_CMD, CFE_ADDR_RESULT,
      CFE_ADDR_THIRD, CFE_ADDR_EXT, CFE_ADDR_TRAP, CFE_ADDR_BIT: cfe_is_mapped = 1'b1;
      default: cfe_is_mapped = 1'b0;
    endcase
  endfunction

  cfe_cond_eval u_eval (
    .code_in(cond_code),
    .flags_in(flags),
    .met_out(cond_now)
  );

  cfe_saturator #(.DW(DW)) u_sat (
    .wide_in(sum_wide),
    .word_out(sat_word),
    .clamped_out(sat_clamp)
  );

  // apb decode: zero wait states, read data captured in the setup cycle
  always_comb begin
    mapped = cfe_is_mapped(paddr_in);
    setup_rd = psel_in & ~penable_in & ~pwrite_in;
    wr_acc = psel_in & penable_in & pwrite_in & mapped;
    cmd_fire = wr_acc & (paddr_in == CFE_ADDR_CMD);
    op = pwdata_in[CFE_CMD_OP_HI:CFE_CMD_OP_LO];
    sat_en = pwdata_in[CFE_CMD_SAT_EN];
    pready_out = 1'b1;
    pslverr_out = psel_in & penable_in & ~mapped;
  end

  // datapath for the command being written this cycle
  always_comb begin
    bit_byte = bit_ctrl[CFE_BYTE_W-1:0];
    bit_num = bit_ctrl[CFE_BIT_NUM_LO+:CFE_BITN_W];
    bit_op = bit_ctrl[CFE_BIT_OP_LO+:2];
    if (op == CFE_OP_SUB) begin
      sum_wide = {opa[DW-1], opa} - {opb[DW-1], opb};
      carry_sum = {1'b0, opa} - {1'b0, opb};
    end else begin
      sum_wide = {opa[DW-1], opa} + {opb[DW-1], opb};
      carry_sum = {1'b0, opa} + {1'b0, opb};
    end
    product = $signed(opa) * $signed(opb);
    // width field holds width-1, so a zero field extends from bit 0
    ext_mask = ~(({DW{1'b1}} << ext_width) << 1);
    new_byte = bit_byte;
    case (bit_op)
      CFE_BOP_SET: new_byte[bit_num] = 1'b1;
      CFE_BOP_CLEAR: new_byte[bit_num] = 1'b0;
      CFE_BOP_INVERT: new_byte[bit_num] = ~bit_byte[bit_num];
      default: new_byte = bit_byte;
    endcase
    op_res = result;
    op_third = third_register_operand;
    res_flags = '0;
    case (op)
      CFE_OP_ADD, CFE_OP_SUB: begin
        op_res = sat_en ? sat_word : sum_wide[DW-1:0];
        res_flags[CFE_F_CARRY] = carry_sum[DW];
        res_flags[CFE_F_OVERFLOW] = sat_clamp;
        res_flags[CFE_F_SATURATED] = sat_en & sat_clamp;
      end
      CFE_OP_MUL: begin
        op_res = product[DW-1:0];
        op_third = product[2*DW-1:DW];
      end
      CFE_OP_DIV: begin
        // a zero divisor leaves both words alone and reports overflow
        if (opb == '0) begin
          res_flags[CFE_F_OVERFLOW] = 1'b1;
        end else begin
          op_res = opa / opb;
          op_third = opa % opb;
        end
      end
      CFE_OP_SEXT: begin
        op_res = (opa & ext_mask) | (opa[ext_width] ? ~ext_mask : '0);
      end
      CFE_OP_ZEXT: begin
        op_res = opa & ext_mask;
      end
      CFE_OP_BITOP: begin
        op_res = {{(DW-CFE_BYTE_W){1'b0}}, new_byte};
      end
      default: begin
        op_res = result;
      end
    endcase
    res_flags[CFE_F_SIGN] = op_res[DW-1];
    res_flags[CFE_F_ZERO] = (op_res == '0);
    // bit test reports the inverted old bit, as the zero flag
    if (op == CFE_OP_BITOP) begin
      res_flags[CFE_F_ZERO] = ~bit_byte[bit_num];
      res_flags[CFE_F_SIGN] = 1'b0;
    end
  end

  // register next values
  always_comb begin
    next_flags = flags;
    next_saved_flags = saved_flags;
    next_cond_code = cond_code;
    next_flag_act = flag_act;
    next_opa = opa;
    next_opb = opb;
    next_result = result;
    next_third_register_operand = third_register_operand;
    next_ext_width = ext_width;
    next_trap_vector = trap_vector;
    next_bit_ctrl = bit_ctrl;
    next_cond_met = cond_now;
    next_rdata = rdata;
    if (wr_acc) begin
      case (paddr_in)
        CFE_ADDR_FLAGS: next_flags = pwdata_in[CFE_NFLAGS-1:0];
        CFE_ADDR_COND: next_cond_code = pwdata_in[CFE_COND_W-1:0];
        CFE_ADDR_FACT: next_flag_act = pwdata_in[2*CFE_NFLAGS-1:0];
        CFE_ADDR_SAVED: next_saved_flags = pwdata_in[CFE_NFLAGS-1:0];
        CFE_ADDR_OPA: next_opa = pwdata_in;
        CFE_ADDR_OPB: next_opb = pwdata_in;
        CFE_ADDR_EXT: next_ext_width = pwdata_in[CFE_EXT_W-1:0];
        CFE_ADDR_TRAP: next_trap_vector = pwdata_in[CFE_TRAP_W-1:0];
        CFE_ADDR_BIT: next_bit_ctrl = pwdata_in[CFE_BIT_CTRL_W-1:0];
        default: next_flags = flags;
      endcase
    end
    if (cmd_fire) begin
      next_result = op_res;
      next_third_register_operand = op_third;
      for (int i = 0; i < CFE_NFLAGS; i++) begin
        case (flag_act[2*i+:2])
          CFE_FA_CLEAR: next_flags[i] = 1'b0;
          CFE_FA_RESULT: next_flags[i] = res_flags[i];
          CFE_FA_RESTORE: next_flags[i] = saved_flags[i];
          default: next_flags[i] = flags[i];
        endcase
      end
    end
    if (setup_rd) begin
      next_rdata = '0;
      case (paddr_in)
        CFE_ADDR_FLAGS: next_rdata[CFE_NFLAGS-1:0] = flags;
        CFE_ADDR_COND: begin
          next_rdata[CFE_COND_W-1:0] = cond_code;
          next_rdata[CFE_COND_MET_BIT] = cond_met;
        end
        CFE_ADDR_FACT: next_rdata[2*CFE_NFLAGS-1:0] = flag_act;
        CFE_ADDR_SAVED: next_rdata[CFE_NFLAGS-1:0] = saved_flags;
        CFE_ADDR_OPA: next_rdata = opa;
        CFE_ADDR_OPB: next_rdata = opb;
        CFE_ADDR_RESULT: next_rdata = result;
        CFE_ADDR_THIRD: next_rdata = third_register_operand;
        CFE_ADDR_EXT: next_rdata[CFE_EXT_W-1:0] = ext_width;
        CFE_ADDR_TRAP: next_rdata[CFE_TRAP_W-1:0] = trap_vector;
        CFE_ADDR_BIT: next_rdata[CFE_BIT_CTRL_W-1:0] = bit_ctrl;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags <= '0;
      saved_flags <= '0;
      cond_code <= CFE_CC_OVERFLOW;
      flag_act <= '0;
      opa <= '0;
      opb <= '0;
      result <= '0;
      third_register_operand <= '0;
      ext_width <= '0;
      trap_vector <= '0;
      bit_ctrl <= '0;
      cond_met <= 1'b0;
      rdata <= '0;
    end else begin
      flags <= next_flags;
      saved_flags <= next_saved_flags;
      cond_code <= next_cond_code;
      flag_act <= next_flag_act;
      opa <= next_opa;
      opb <= next_opb;
      result <= next_result;
      third_register_operand <= next_third_register_operand;
      ext_width <= next_ext_width;
      trap_vector <= next_trap_vector;
      bit_ctrl <= next_bit_ctrl;
      cond_met <= next_cond_met;
      rdata <= next_rdata;
    end
  end

  always_comb begin
    prdata_out = rdata;
    flags_out = flags;
    cond_met_out = cond_met;
    trap_vector_out = trap_vector;
  end

  // checks
  logic cond_alt;

  cfe_cond_eval u_eval_alt (
    .code_in(cond_code ^ CFE_CC_NO_OVERFLOW),
    .flags_in(flags),
    .met_out(cond_alt)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_cond_set;
    (cond_code == CFE_CC_CARRY) |=> cond_met_out == $past(flags[CFE_F_CARRY]);
  endproperty
  a_cond_set: assert property (p_cond_set) else $error("carry code verdict wrong");

  property p_cond_clear;
    (cond_code == CFE_CC_NOT_ZERO) |=> cond_met_out == !$past(flags[CFE_F_ZERO]);
  endproperty
  a_cond_clear: assert property (p_cond_clear) else $error("not-zero verdict wrong");

  property p_cond_higher;
    (cond_code == CFE_CC_HIGHER)
      |=> cond_met_out == !($past(flags[CFE_F_CARRY]) | $past(flags[CFE_F_ZERO]));
  endproperty
  a_cond_higher: assert property (p_cond_higher) else $error("higher verdict wrong");

  property p_cond_always;
    (cond_code == CFE_CC_ALWAYS) |=> cond_met_out;
  endproperty
  a_cond_always: assert property (p_cond_always) else $error("always code false");

  property p_cond_sless;
    (cond_code == CFE_CC_SIGNED_LESS)
      |=> cond_met_out == ($past(flags[CFE_F_SIGN]) ^ $past(flags[CFE_F_OVERFLOW]));
  endproperty
  a_cond_sless: assert property (p_cond_sless) else $error("signed less wrong");

  property p_cond_sgreater;
    (cond_code == CFE_CC_SIGNED_GREATER) |=> cond_met_out == !(($past(flags[CFE_F_SIGN])
      ^ $past(flags[CFE_F_OVERFLOW])) | $past(flags[CFE_F_ZERO]));
  endproperty
  a_cond_sgreater: assert property (p_cond_sgreater) else $error("signed greater wrong");

  property p_cond_pair;
    (cond_code[2:0] != CFE_CC_ALWAYS[2:0]) |-> cond_now != cond_alt;
  endproperty
  a_cond_pair: assert property (p_cond_pair) else $error("code pair not complementary");

  property p_sat_clamp;
    (cmd_fire && sat_en && sat_clamp && (op == CFE_OP_ADD || op == CFE_OP_SUB))
      |=> result == ($past(sum_wide[DW]) ? CFE_SAT_MIN : CFE_SAT_MAX);
  endproperty
  a_sat_clamp: assert property (p_sat_clamp) else $error("saturation limit wrong");

  property p_flag_restore;
    (cmd_fire && flag_act[2*CFE_F_ZERO+:2] == CFE_FA_RESTORE)
      |=> flags[CFE_F_ZERO] == $past(saved_flags[CFE_F_ZERO]);
  endproperty
  a_flag_restore: assert property (p_flag_restore) else $error("zero flag not restored");

  property p_flag_clear;
    (cmd_fire && flag_act[2*CFE_F_CARRY+:2] == CFE_FA_CLEAR) |=> !flags[CFE_F_CARRY];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("carry not cleared");

  property p_zext;
    (cmd_fire && op == CFE_OP_ZEXT) |=> ((result >> $past(ext_width)) >> 1) == '0;
  endproperty
  a_zext: assert property (p_zext) else $error("zero extension left high bits");

  property p_trap;
    (wr_acc && paddr_in == CFE_ADDR_TRAP)
      |=> trap_vector_out == $past(pwdata_in[CFE_TRAP_W-1:0]);
  endproperty
  a_trap: assert property (p_trap) else $error("trap vector not taken");

  property p_third_mul;
    (cmd_fire && op == CFE_OP_MUL) |=> third_register_operand == $past(product[2*DW-1:DW]);
  endproperty
  a_third_mul: assert property (p_third_mul) else $error("product high word lost");

  property p_bit_set;
    (cmd_fire && op == CFE_OP_BITOP && bit_op == CFE_BOP_SET) |=> result[$past(bit_num)];
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("selected bit not set");

  c_sat: cover property (cmd_fire && sat_en && sat_clamp);
  c_restore: cover property (cmd_fire && flag_act[2*CFE_F_ZERO+:2] == CFE_FA_RESTORE);
  c_sgreater_met: cover property (cond_code == CFE_CC_SIGNED_GREATER && cond_met_out);
  c_div: cover property (cmd_fire && op == CFE_OP_DIV && opb != '0);
endmodule // cfe_condition_flag_evaluator

// File: tb/cfe_core_model.sv
/*
  Core-side model: samples the evaluator outputs the way the branch unit does.
  Assumes the evaluator holds flags and verdict as levels between writes.
*/
`timescale 1ns/1ps
module cfe_core_model
  import cfe_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // evaluator outputs
  input wire logic cond_met_in,
  input wire logic [CFE_NFLAGS-1:0] flags_in,
  // sampled view
  output logic taken_out,
  output logic [CFE_NFLAGS-1:0] flags_seen_out
);
  logic next_taken;
  logic [CFE_NFLAGS-1:0] next_flags_seen;
  // the branch unit acts only on values held at a clock edge
  always_comb begin
    next_taken = sys_rst_in ? 1'h0 : cond_met_in;
    next_flags_seen = sys_rst_in ? '0 : flags_in;
  end
  always_ff @(posedge clk_in) begin
    taken_out <= next_taken;
    flags_seen_out <= next_flags_seen;
  end
endmodule // cfe_core_model

// File: tb/cfe_condition_flag_evaluator_test.sv
/*
  Self-checking bench: APB register accesses with expected values.
  Assumes the slave answers with pready; waits are bounded by a retry count.
*/
`timescale 1ns/1ps
module cfe_condition_flag_evaluator_test;
  import cfe_pkg::*;
  logic clk_in, sys_rst_in, psel, penable, pwrite, pready, pslverr, cond_met, taken, err;
  logic [CFE_AW-1:0] paddr;
  logic [CFE_DW-1:0] pwdata, prdata, rd;
  logic [CFE_NFLAGS-1:0] flags, flags_seen;
  logic [CFE_TRAP_W-1:0] trap;
  logic [15:0] met_seen;
  logic [7:0] bexp;
  int fail_count, comparisons;

  cfe_condition_flag_evaluator dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .flags_out(flags),
    .cond_met_out(cond_met), .trap_vector_out(trap));
  cfe_core_model core (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cond_met_in(cond_met),
    .flags_in(flags), .taken_out(taken), .flags_seen_out(flags_seen));

  initial begin
    clk_in = 1'h0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one transfer; the request holds until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    check({31'h0, pready}, 32'h1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic op(input logic [31:0] a, input logic [31:0] b, input logic [3:0] cmd);
    apb(1'h1, CFE_ADDR_OPA, a);
    apb(1'h1, CFE_ADDR_OPB, b);
    apb(1'h1, CFE_ADDR_CMD, {28'h0, cmd});
  endtask

  // flags: carry, overflow, sign, zero, saturated from bit 0 up
  function automatic logic ev(input logic [3:0] c, input logic [4:0] f);
    logic b;
    case (c[2:0])
      3'h0: b = f[1];
      3'h1: b = f[0];
      3'h2: b = f[3];
      3'h3: b = f[0] | f[3];
      3'h4: b = f[2];
      3'h6: b = f[2] ^ f[1];
      3'h7: b = (f[2] ^ f[1]) | f[3];
      default: b = 1'h1;
    endcase
    if (c == 4'hd) return f[4];
    return (c[3] && c != 4'hd) ? ~b : b;
  endfunction

  initial begin
    repeat (30000) @(posedge clk_in);
    fail_count++;
    final_report();
  end

  initial begin
    sys_rst_in = 1'h1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    rdc(CFE_ADDR_FLAGS, 32'h0);
    for (int f = 0; f < 32; f++) begin
      apb(1'h1, CFE_ADDR_FLAGS, f);
      for (int c = 0; c < 16; c++) begin
        apb(1'h1, CFE_ADDR_COND, c);
        repeat (3) @(posedge clk_in);
        check({31'h0, cond_met}, {31'h0, ev(c[3:0], f[4:0])});
        met_seen[c] = cond_met;
        rdc(CFE_ADDR_COND, {23'h0, ev(c[3:0], f[4:0]), 4'h0, c[3:0]});
        check({31'h0, taken}, {31'h0, ev(c[3:0], f[4:0])});
      end
      for (int c = 0; c < 8; c++)
        if (c != 5) check({31'h0, met_seen[c]}, {31'h0, ~met_seen[c+8]});
    end
    apb(1'h1, CFE_ADDR_FACT, 32'h2aa);
    op(32'h7fffffff, 32'h1, 4'h8);
    rdc(CFE_ADDR_RESULT, 32'h7fffffff);
    rdc(CFE_ADDR_FLAGS, 32'h12);
    op(32'h80000000, 32'h1, 4'h9);
    rdc(CFE_ADDR_RESULT, 32'h80000000);
    rdc(CFE_ADDR_FLAGS, 32'h16);
    op(32'h5, 32'h3, 4'h8);
    rdc(CFE_ADDR_RESULT, 32'h8);
    // keep carry, clear overflow, sign and zero from result, restore saturated
    apb(1'h1, CFE_ADDR_FLAGS, 32'h1f);
    apb(1'h1, CFE_ADDR_SAVED, 32'h10);
    apb(1'h1, CFE_ADDR_FACT, 32'h3a4);
    op(32'h1, 32'h1, 4'h0);
    rdc(CFE_ADDR_FLAGS, 32'h11);
    check({27'h0, flags_seen}, 32'h11);
    // clear carry and restore zero, so the clear and restore paths both fire
    apb(1'h1, CFE_ADDR_FLAGS, 32'h01);
    apb(1'h1, CFE_ADDR_SAVED, 32'h08);
    apb(1'h1, CFE_ADDR_FACT, 32'h0c1);
    op(32'h1, 32'h1, 4'h0);
    rdc(CFE_ADDR_FLAGS, 32'h08);
    apb(1'h1, CFE_ADDR_FACT, 32'h0);
    op(32'hfffffffe, 32'h3, 4'h2);
    rdc(CFE_ADDR_RESULT, 32'hfffffffa);
    rdc(CFE_ADDR_THIRD, 32'hffffffff);
    op(32'h11, 32'h5, 4'h3);
    rdc(CFE_ADDR_RESULT, 32'h3);
    rdc(CFE_ADDR_THIRD, 32'h2);
    apb(1'h1, CFE_ADDR_EXT, 32'h7);
    op(32'h80, 32'h0, 4'h4);
    rdc(CFE_ADDR_RESULT, 32'hffffff80);
    op(32'h80, 32'h0, 4'h5);
    rdc(CFE_ADDR_RESULT, 32'h80);
    for (int k = 0; k < 4; k++) begin
      // clear works on bit 3, which is high, so a dead clear shows up
      bexp = (k == 0) ? 8'h5a : (k == 1) ? 8'h5e : (k == 2) ? 8'h52 : 8'h5e;
      apb(1'h1, CFE_ADDR_BIT, {19'h0, k[1:0], ((k == 2) ? 3'h3 : 3'h2), 8'h5a});
      apb(1'h1, CFE_ADDR_CMD, 32'h6);
      rdc(CFE_ADDR_RESULT, {24'h0, bexp});
    end
    apb(1'h1, CFE_ADDR_TRAP, 32'h3f);
    rdc(CFE_ADDR_TRAP, 32'h1f);
    check({31'h0, err}, 32'h0);
    check({27'h0, trap}, 32'h1f);
    rdc(8'h30, 32'h0);
    check({31'h0, err}, 32'h1);
    final_report();
  end
endmodule // cfe_condition_flag_evaluator_test
